// >>> inc/ddrb_pkg.sv
package ddrb_pkg;

  // Word and burst geometry
  localparam int DATA_W = 36;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int BEATS  = 4;
  localparam int ADDR_W = 19;

  // Beat positions within a burst
  localparam int B0 = 0;
  localparam int B1 = 1;
  localparam int B2 = 2;
  localparam int B3 = 3;

  // Half of a burst held in one array word
  localparam logic HALF_LO = 1'h0;
  localparam logic HALF_HI = 1'h1;

  // Timing counts in clock cycles
  localparam int ZQ_SETTLE_CYCLES = 2048;
  localparam int ZQ_STEP_CYCLES   = 16;
  localparam int ZQ_RECAL_CYCLES  = 8192;
  localparam int DLL_LOCK_CYCLES  = 1024;

  // Driver impedance code
  localparam int         CODE_W   = 6;
  localparam logic [5:0] CODE_MID = 6'h20;
  localparam logic [5:0] CODE_MAX = 6'h3F;
  localparam logic [5:0] CODE_MIN = 6'h00;

  // Commit queue
  localparam int         FIFO_DEPTH = 16;
  localparam int         FIFO_SPARE = 4;
  localparam logic [1:0] EV_NONE    = 2'h0;
  localparam logic [1:0] EV_LAST    = 2'h1;
  localparam logic [1:0] EV_BOTH    = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0]                  addr;
    logic [BEATS-1:0][LANES-1:0]        en;
    logic [BEATS-1:0][DATA_W-1:0]       data;
  } ddrb_burst_t;

  typedef struct packed {
    logic [ADDR_W:0]                    addr;
    logic [2*LANES-1:0]                 en;
    logic [2*DATA_W-1:0]                data;
  } ddrb_commit_t;

  typedef enum logic [1:0] {DLL_OFF, DLL_LOCKING, DLL_LOCKED} ddrb_dll_t;
  typedef enum logic {ZQ_INIT, ZQ_TRACK} ddrb_zq_t;

endpackage

// >>> rtl/ddrb_store.sv
`timescale 1ns/1ps
module ddrb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic          push;
  logic          pop;

  assign in_ready  = level != CW'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp    <= '0;
      rp    <= '0;
      level <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= wp + AW'(1);
      end
      if (pop)
      begin
        rp <= rp + AW'(1);
      end
      level <= level + CW'(push) - CW'(pop);
    end
  end
endmodule // ddrb_fifo

module ddrb_ram #(
  parameter int LANE_W = 9,
  parameter int LANES  = 8,
  parameter int AW     = 20
) (
  input  wire logic                    clk,
  input  wire logic                    wr_en,
  input  wire logic [AW-1:0]           wr_addr,
  input  wire logic [LANES-1:0]        wr_lane,
  input  wire logic [LANES*LANE_W-1:0] wr_data,
  input  wire logic [AW-1:0]           rd_addr,
  output logic [LANES*LANE_W-1:0]      rd_data
);
  // One array per lane so each lane has a single writer
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane
    logic [LANE_W-1:0] mem [2**AW];
    always_ff @(posedge clk)
    begin
      if (wr_en && wr_lane[l])
      begin
        mem[wr_addr] <= wr_data[l*LANE_W +: LANE_W];
      end
      rd_data[l*LANE_W +: LANE_W] <= mem[rd_addr];
    end
  end
endmodule // ddrb_ram

// >>> rtl/ddrb_port_ctrl.sv
`timescale 1ns/1ps
module ddrb_port_ctrl
  import ddrb_pkg::*;
#(
  parameter int ZQ_RECAL = ZQ_RECAL_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                read_select_n,
  input  wire logic                write_select_n,
  input  wire logic [ADDR_W-1:0]   address_in,
  input  wire logic [DATA_W-1:0]   data_in_rise,
  input  wire logic [DATA_W-1:0]   data_in_fall,
  input  wire logic [LANES-1:0]    byte_write_n_rise,
  input  wire logic [LANES-1:0]    byte_write_n_fall,
  input  wire logic                dll_off_n,
  input  wire logic                impedance_ref_pin,
  output logic [DATA_W-1:0]        q_rise,
  output logic [DATA_W-1:0]        q_fall,
  output logic                     q_rise_en,
  output logic                     q_fall_en,
  output logic                     write_refused,
  output logic                     dll_locked,
  output logic [CODE_W-1:0]        impedance_code,
  output logic                     impedance_ready
);
  localparam int LVL_W = $clog2(FIFO_DEPTH+1);
  localparam int DLL_W = $clog2(DLL_LOCK_CYCLES);
  localparam int ZQ_W  = $clog2(ZQ_RECAL > ZQ_SETTLE_CYCLES ?
                                ZQ_RECAL : ZQ_SETTLE_CYCLES);
  localparam int STP_W = $clog2(ZQ_STEP_CYCLES);

  // Lanes of base replaced where buffer b holds enabled bytes for a, beat k
  function automatic logic [DATA_W-1:0] pick(
    input logic [DATA_W-1:0] base,
    input ddrb_burst_t       b,
    input logic              v,
    input logic [ADDR_W-1:0] a,
    input int                k);
    logic [DATA_W-1:0] r;
    r = base;
    for (int l = 0; l < LANES; l++)
    begin
      if (v && b.addr == a && b.en[k][l])
      begin
        r[l*LANE_W +: LANE_W] = b.data[k][l*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  logic         dll_meta;
  logic         dll_sync;
  logic         zq_meta;
  logic         zq_sync;

  logic         rd_req;
  logic         wr_req;
  logic         rd_go;
  logic         wr_ok;
  logic         wr_go;
  logic         wr_block;
  logic         rd_last;
  logic         wr_last;
  logic         nop_last;

  logic         ws1;
  logic         ws2;
  logic         ws3;
  logic         slot;
  logic         ws1_slot;
  logic         ws2_slot;
  logic         ws3_slot;
  ddrb_burst_t  assem [2];
  ddrb_burst_t  done_burst;
  ddrb_burst_t  buf0;
  ddrb_burst_t  buf1;
  ddrb_burst_t  ev;
  logic         buf0_v;
  logic         buf1_v;
  logic [1:0]   ev_cnt;

  ddrb_commit_t push_word;
  ddrb_commit_t head;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [LVL_W-1:0] fifo_level;

  logic         rs1;
  logic         rs2;
  logic         rs3;
  logic         rs4;
  logic [ADDR_W-1:0] rs1_addr;
  logic [ADDR_W-1:0] rs2_addr;
  logic [ADDR_W-1:0] rs3_addr;
  logic         rd_issue;
  logic [ADDR_W:0] rd_issue_addr;
  logic [2*DATA_W-1:0] ram_rd;
  logic [DATA_W-1:0] hold_b1;
  logic [DATA_W-1:0] hold_b3;

  ddrb_dll_t    dll_st;
  logic [DLL_W-1:0] dll_cnt;
  ddrb_zq_t     zq_st;
  logic [ZQ_W-1:0]  zq_cnt;
  logic [STP_W-1:0] zq_step;
  logic         zq_tick;

  // Pins without a timing relation to clk
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dll_meta <= 1'h0;
      dll_sync <= 1'h0;
      zq_meta  <= 1'h0;
      zq_sync  <= 1'h0;
    end
    else
    begin
      dll_meta <= dll_off_n;
      dll_sync <= dll_meta;
      zq_meta  <= impedance_ref_pin;
      zq_sync  <= zq_meta;
    end
  end

  // Command decode
  assign rd_req   = !read_select_n;
  assign wr_req   = !write_select_n;
  assign rd_go    = rd_req && !rd_last;
  assign wr_ok    = wr_req && !wr_last && !(rd_req && nop_last);
  // Room for this burst's later eviction plus one in flight
  assign wr_block = fifo_level > LVL_W'(FIFO_DEPTH - FIFO_SPARE);
  assign wr_go    = wr_ok && !wr_block;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_last       <= 1'h0;
      wr_last       <= 1'h0;
      nop_last      <= 1'h0;
      write_refused <= 1'h0;
    end
    else
    begin
      rd_last       <= rd_go;
      wr_last       <= wr_go;
      nop_last      <= !rd_req && !wr_req;
      write_refused <= wr_ok && wr_block;
    end
  end

  // Write beat pipeline, runs on regardless of later selects
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ws1      <= 1'h0;
      ws2      <= 1'h0;
      ws3      <= 1'h0;
      slot     <= 1'h0;
      ws1_slot <= 1'h0;
      ws2_slot <= 1'h0;
      ws3_slot <= 1'h0;
    end
    else
    begin
      ws1      <= wr_go;
      ws2      <= ws1;
      ws3      <= ws2;
      slot     <= slot ^ wr_go;
      ws1_slot <= slot;
      ws2_slot <= ws1_slot;
      ws3_slot <= ws2_slot;
    end
  end

  // Two slots, since a new burst overlaps the last beat of the previous
  always_ff @(posedge clk)
  begin
    if (wr_go)
    begin
      assem[slot].addr <= address_in;
    end
    if (ws1)
    begin
      assem[ws1_slot].data[B0] <= data_in_rise;
      assem[ws1_slot].en[B0]   <= ~byte_write_n_rise;
    end
    if (ws2)
    begin
      assem[ws2_slot].data[B1] <= data_in_fall;
      assem[ws2_slot].en[B1]   <= ~byte_write_n_fall;
      assem[ws2_slot].data[B2] <= data_in_rise;
      assem[ws2_slot].en[B2]   <= ~byte_write_n_rise;
    end
  end

  always_comb
  begin
    done_burst          = assem[ws3_slot];
    done_burst.data[B3] = data_in_fall;
    done_burst.en[B3]   = ~byte_write_n_fall;
  end

  // Late-write buffers: newest two bursts stay out of the array
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      buf0   <= '0;
      buf1   <= '0;
      buf0_v <= 1'h0;
      buf1_v <= 1'h0;
    end
    else if (ws3)
    begin
      buf0   <= done_burst;
      buf1   <= buf0;
      buf0_v <= 1'h1;
      buf1_v <= buf0_v;
    end
  end

  // Oldest buffer evicted as two array words on the third write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ev     <= '0;
      ev_cnt <= EV_NONE;
    end
    else if (ws3 && buf1_v)
    begin
      ev     <= buf1;
      ev_cnt <= EV_BOTH;
    end
    else if (ev_cnt != EV_NONE && fifo_in_ready)
    begin
      ev_cnt <= ev_cnt - EV_LAST;
    end
  end

  always_comb
  begin
    push_word.addr = {ev.addr, ev_cnt == EV_BOTH ? HALF_LO : HALF_HI};
    if (ev_cnt == EV_BOTH)
    begin
      push_word.en   = {ev.en[B1], ev.en[B0]};
      push_word.data = {ev.data[B1], ev.data[B0]};
    end
    else
    begin
      push_word.en   = {ev.en[B3], ev.en[B2]};
      push_word.data = {ev.data[B3], ev.data[B2]};
    end
  end

  // Drain stalls rather than write the word being read this edge
  assign fifo_out_ready = !(rd_issue && rd_issue_addr == head.addr);

  ddrb_fifo #(
    .W     ($bits(ddrb_commit_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_commit (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (ev_cnt != EV_NONE),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (head),
    .level     (fifo_level)
  );

  ddrb_ram #(
    .LANE_W (LANE_W),
    .LANES  (2*LANES),
    .AW     (ADDR_W+1)
  ) u_array (
    .clk     (clk),
    .wr_en   (fifo_out_valid && fifo_out_ready),
    .wr_addr (head.addr),
    .wr_lane (head.en),
    .wr_data (head.data),
    .rd_addr (rd_issue_addr),
    .rd_data (ram_rd)
  );

  // Read pipeline, independent of the write side
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rs1      <= 1'h0;
      rs2      <= 1'h0;
      rs3      <= 1'h0;
      rs4      <= 1'h0;
      rs1_addr <= '0;
      rs2_addr <= '0;
      rs3_addr <= '0;
    end
    else
    begin
      rs1 <= rd_go;
      rs2 <= rs1;
      rs3 <= rs2;
      rs4 <= rs3;
      if (rd_go)
      begin
        rs1_addr <= address_in;
      end
      rs2_addr <= rs1_addr;
      rs3_addr <= rs2_addr;
    end
  end

  assign rd_issue      = rs1 || rs2;
  assign rd_issue_addr = rs1 ? {rs1_addr, HALF_LO} : {rs2_addr, HALF_HI};

  // Output stages move only on a clock edge or on rst; a stopped clock freezes them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_rise    <= '0;
      q_fall    <= '0;
      hold_b1   <= '0;
      hold_b3   <= '0;
      q_rise_en <= 1'h0;
      q_fall_en <= 1'h0;
    end
    else
    begin
      q_fall_en <= rs2 || rs3;
      q_rise_en <= rs3 || rs4;
      if (rs2)
      begin
        q_fall  <= pick(pick(pick(ram_rd[DATA_W-1:0], ev, ev_cnt != EV_NONE,
                   rs2_addr, B0), buf1, buf1_v, rs2_addr, B0),
                   buf0, buf0_v, rs2_addr, B0);
        hold_b1 <= pick(pick(pick(ram_rd[2*DATA_W-1:DATA_W], ev,
                   ev_cnt != EV_NONE, rs2_addr, B1), buf1, buf1_v,
                   rs2_addr, B1), buf0, buf0_v, rs2_addr, B1);
      end
      if (rs3)
      begin
        q_rise  <= hold_b1;
        q_fall  <= pick(pick(pick(ram_rd[DATA_W-1:0], ev, ev_cnt != EV_NONE,
                   rs3_addr, B2), buf1, buf1_v, rs3_addr, B2),
                   buf0, buf0_v, rs3_addr, B2);
        hold_b3 <= pick(pick(pick(ram_rd[2*DATA_W-1:DATA_W], ev,
                   ev_cnt != EV_NONE, rs3_addr, B3), buf1, buf1_v,
                   rs3_addr, B3), buf0, buf0_v, rs3_addr, B3);
      end
      if (rs4)
      begin
        q_rise <= hold_b3;
      end
    end
  end

  // DLL enable and lock tracking
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dll_st     <= DLL_OFF;
      dll_cnt    <= '0;
      dll_locked <= 1'h0;
    end
    else if (!dll_sync)
    begin
      dll_st     <= DLL_OFF;
      dll_cnt    <= '0;
      dll_locked <= 1'h0;
    end
    else
    begin
      unique case (dll_st)
        DLL_OFF:
        begin
          dll_st <= DLL_LOCKING;
        end
        DLL_LOCKING:
        begin
          dll_cnt <= dll_cnt + DLL_W'(1);
          if (dll_cnt == DLL_W'(DLL_LOCK_CYCLES - 1))
          begin
            dll_st     <= DLL_LOCKED;
            dll_locked <= 1'h1;
          end
        end
        DLL_LOCKED:
        begin
          dll_locked <= 1'h1;
        end
        default:
        begin
          dll_st <= DLL_OFF;
        end
      endcase
    end
  end

  // Impedance: fast stepping to settle, then slow periodic tracking
  assign zq_tick = (zq_st == ZQ_INIT) ? (zq_step == '0)
                 : (zq_cnt == ZQ_W'(ZQ_RECAL - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      zq_st           <= ZQ_INIT;
      zq_cnt          <= '0;
      zq_step         <= '0;
      impedance_code  <= CODE_MID;
      impedance_ready <= 1'h0;
    end
    else
    begin
      zq_step <= zq_step + STP_W'(1);
      zq_cnt  <= zq_cnt + ZQ_W'(1);
      if (zq_tick)
      begin
        if (zq_sync && impedance_code != CODE_MAX)
        begin
          impedance_code <= impedance_code + CODE_W'(1);
        end
        else if (!zq_sync && impedance_code != CODE_MIN)
        begin
          impedance_code <= impedance_code - CODE_W'(1);
        end
      end
      unique case (zq_st)
        ZQ_INIT:
        begin
          if (zq_cnt == ZQ_W'(ZQ_SETTLE_CYCLES - 1))
          begin
            zq_st           <= ZQ_TRACK;
            zq_cnt          <= '0;
            impedance_ready <= 1'h1;
          end
        end
        ZQ_TRACK:
        begin
          if (zq_tick)
          begin
            zq_cnt <= '0;
          end
        end
      endcase
    end
  end

endmodule // ddrb_port_ctrl

// >>> verif/ddrb_port_chk.sv
`timescale 1ns/1ps
module ddrb_port_chk
  import ddrb_pkg::*;
#(
  parameter int ZQ_RECAL = ZQ_RECAL_CYCLES
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              read_select_n,
  input wire logic              write_select_n,
  input wire logic [ADDR_W-1:0] address_in,
  input wire logic [DATA_W-1:0] data_in_rise,
  input wire logic [DATA_W-1:0] data_in_fall,
  input wire logic [LANES-1:0]  byte_write_n_rise,
  input wire logic [LANES-1:0]  byte_write_n_fall,
  input wire logic              dll_off_n,
  input wire logic              impedance_ref_pin,
  input wire logic [DATA_W-1:0] q_rise,
  input wire logic [DATA_W-1:0] q_fall,
  input wire logic              q_rise_en,
  input wire logic              q_fall_en,
  input wire logic              write_refused,
  input wire logic              dll_locked,
  input wire logic [CODE_W-1:0] impedance_code,
  input wire logic              impedance_ready
);
  logic        rd_prev;
  logic        wr_prev;
  logic        idle_prev;
  logic [11:0] hi_cnt;
  logic [11:0] up_cnt;
  logic        rd_acc;
  logic        wr_acc;

  assign rd_acc = !rst && !read_select_n && !rd_prev;
  assign wr_acc = !rst && !write_select_n && !wr_prev
                  && !(!read_select_n && idle_prev);

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rd_prev   <= 1'h0;
      wr_prev   <= 1'h0;
      idle_prev <= 1'h0;
    end
    else
    begin
      rd_prev   <= rd_acc;
      wr_prev   <= wr_acc;
      idle_prev <= read_select_n && write_select_n;
    end

  // Saturating counts; only thresholds matter
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      hi_cnt <= 12'h000;
      up_cnt <= 12'h000;
    end
    else
    begin
      hi_cnt <= !dll_off_n ? 12'h000 : hi_cnt + 12'(hi_cnt != 12'hFFF);
      up_cnt <= up_cnt + 12'(up_cnt != 12'hFFF);
    end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_read_beats:
    assert property (rd_acc |-> ##3 q_fall_en ##1 (q_fall_en && q_rise_en)
      ##1 q_rise_en) else $error("read beat enables out of step");
  a_fall_owed:
    assert property (q_fall_en |-> $past(rd_acc, 3) || $past(rd_acc, 4))
      else $error("q_fall driven without a read");
  a_rise_owed:
    assert property (q_rise_en |-> $past(rd_acc, 4) || $past(rd_acc, 5))
      else $error("q_rise driven without a read");
  a_refuse_cause:
    assert property (write_refused |-> $past(wr_acc))
      else $error("refusal without a legal write");
  a_dll_drop:
    assert property (!dll_off_n [*5] |-> !dll_locked)
      else $error("dll still locked while disabled");
  a_dll_early:
    assert property ($rose(dll_locked) |-> hi_cnt >= 12'h400)
      else $error("dll locked too early");
  a_dll_due:
    assert property (hi_cnt >= 12'h410 |-> dll_locked)
      else $error("dll lock overdue");
  a_imp_mid:
    assert property ($fell(rst) |-> impedance_code == CODE_MID
      && !impedance_ready) else $error("impedance not at mid start");
  a_imp_due:
    assert property (up_cnt >= 12'h802 |-> impedance_ready)
      else $error("impedance settle overdue");

  c_read: cover property (rd_acc ##3 q_fall_en);
  c_write_pair: cover property (wr_acc ##1 !write_select_n);
  c_lock: cover property ($rose(dll_locked));
  c_ready: cover property ($rose(impedance_ready));
endmodule // ddrb_port_chk

bind ddrb_port_ctrl ddrb_port_chk #(.ZQ_RECAL(ZQ_RECAL)) chk_u (
  .clk(clk), .rst(rst), .read_select_n(read_select_n),
  .write_select_n(write_select_n), .address_in(address_in),
  .data_in_rise(data_in_rise), .data_in_fall(data_in_fall),
  .byte_write_n_rise(byte_write_n_rise),
  .byte_write_n_fall(byte_write_n_fall), .dll_off_n(dll_off_n),
  .impedance_ref_pin(impedance_ref_pin), .q_rise(q_rise),
  .q_fall(q_fall), .q_rise_en(q_rise_en), .q_fall_en(q_fall_en),
  .write_refused(write_refused), .dll_locked(dll_locked),
  .impedance_code(impedance_code), .impedance_ready(impedance_ready));

// >>> verif/ddrb_ctl_model.sv
`timescale 1ns/1ps
module ddrb_ctl_model
  import ddrb_pkg::*;
(
  input  wire logic         clk,
  output logic              read_select_n,
  output logic              write_select_n,
  output logic [ADDR_W-1:0] address_in,
  output logic [DATA_W-1:0] data_in_rise,
  output logic [DATA_W-1:0] data_in_fall,
  output logic [LANES-1:0]  byte_write_n_rise,
  output logic [LANES-1:0]  byte_write_n_fall,
  output logic              dll_off_n
);
  ddrb_burst_t w0, w1, w2, w3;
  logic        v0, v1, v2, v3;

  initial
  begin
    {read_select_n, write_select_n} = 2'h3;
    {address_in, data_in_rise, data_in_fall} = '0;
    {byte_write_n_rise, byte_write_n_fall} = 8'hFF;
    dll_off_n = 1'h0;
    {v0, v1, v2, v3} = 4'h0;
  end

  task automatic set_dll(input logic v);
    dll_off_n = v;
  endtask

  // One call per edge; lines with no beat owed toggle so nothing stale
  task automatic cmd(input logic rd, input logic wr, input logic send,
                     input ddrb_burst_t b);
    @(posedge clk);
    #1;
    {v3, v2, v1} = {v2, v1, v0};
    {w3, w2, w1} = {w2, w1, w0};
    if (v1)
      {data_in_rise, byte_write_n_rise} = {w1.data[B0], w1.en[B0]};
    else if (v2)
      {data_in_rise, byte_write_n_rise} = {w2.data[B2], w2.en[B2]};
    else
      {data_in_rise, byte_write_n_rise} =
        ~{data_in_rise, byte_write_n_rise};
    if (v2)
      {data_in_fall, byte_write_n_fall} = {w2.data[B1], w2.en[B1]};
    else if (v3)
      {data_in_fall, byte_write_n_fall} = {w3.data[B3], w3.en[B3]};
    else
      {data_in_fall, byte_write_n_fall} =
        ~{data_in_fall, byte_write_n_fall};
    {v0, w0} = {send, b};
    read_select_n = !rd;
    write_select_n = !wr;
    address_in = (rd || wr) ? b.addr : ~address_in;
  endtask
endmodule // ddrb_ctl_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench
  import ddrb_pkg::*;
;
  logic              clk, rst, zq, prd, pwr, pidle;
  logic              read_select_n, write_select_n, dll_off_n;
  logic [ADDR_W-1:0] address_in;
  logic [DATA_W-1:0] data_in_rise, data_in_fall, q_rise, q_fall;
  logic [LANES-1:0]  byte_write_n_rise, byte_write_n_fall;
  logic              q_rise_en, q_fall_en, write_refused, dll_locked;
  logic [CODE_W-1:0] impedance_code;
  logic              impedance_ready;
  logic [DATA_W-1:0] mem [0:255];
  integer            seed = 30;
  int                n_fail = 0;
  int                n_checks = 0;

  ddrb_ctl_model m_u (.clk(clk), .read_select_n(read_select_n),
    .write_select_n(write_select_n), .address_in(address_in),
    .data_in_rise(data_in_rise), .data_in_fall(data_in_fall),
    .byte_write_n_rise(byte_write_n_rise),
    .byte_write_n_fall(byte_write_n_fall), .dll_off_n(dll_off_n));
  ddrb_port_ctrl #(.ZQ_RECAL(64)) dut_u (.clk(clk), .rst(rst),
    .read_select_n(read_select_n), .write_select_n(write_select_n),
    .address_in(address_in), .data_in_rise(data_in_rise),
    .data_in_fall(data_in_fall), .byte_write_n_rise(byte_write_n_rise),
    .byte_write_n_fall(byte_write_n_fall), .dll_off_n(dll_off_n),
    .impedance_ref_pin(zq), .q_rise(q_rise), .q_fall(q_fall),
    .q_rise_en(q_rise_en), .q_fall_en(q_fall_en),
    .write_refused(write_refused), .dll_locked(dll_locked),
    .impedance_code(impedance_code), .impedance_ready(impedance_ready));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic ddrb_burst_t rnd(input logic full, input int a);
    ddrb_burst_t b;
    for (int k = 0; k < BEATS; k++)
    begin
      b.data[k] = DATA_W'({$random(seed), $random(seed)});
      b.en[k] = full ? 4'h0 : LANES'($random(seed));
    end
    b.addr = ADDR_W'(a);
    return b;
  endfunction

  function automatic int ra();
    return ($random(seed) & 63) % 61;
  endfunction

  task automatic rchk(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] e [BEATS];
    for (int k = 0; k < BEATS; k++)
      e[k] = mem[{a[5:0], 2'(k)}];
    repeat (3) @(posedge clk);
    #2 chk(q_fall, e[B0]);
    chk(36'(q_fall_en), 36'h1);
    @(posedge clk);
    #2 chk(q_fall, e[B2]);
    chk(q_rise, e[B1]);
    @(posedge clk);
    #2 chk(q_rise, e[B3]);
    chk(36'(q_rise_en), 36'h1);
  endtask

  // Acceptance worked out here; beats go out only for taken writes
  task automatic op(input logic rd, input logic wr, input ddrb_burst_t b);
    logic rt;
    logic wt;
    rt = rd && !prd;
    wt = wr && !pwr && !(rd && pidle);
    m_u.cmd(rd, wr, wt, b);
    zq = 1'($random(seed));
    if (rt)
      fork
        rchk(b.addr);
      join_none
    if (wt)
      for (int k = 0; k < BEATS; k++)
        for (int l = 0; l < LANES; l++)
          if (!b.en[k][l])
            mem[{b.addr[5:0], 2'(k)}][l*LANE_W +: LANE_W] =
              b.data[k][l*LANE_W +: LANE_W];
    {prd, pwr, pidle} = {rt, wt, !rd && !wr};
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'h0, 1'h0, '0);
  endtask

  initial
  begin
    #(25 * 20000);
    n_fail++;
    $display("BAD t=%0t seen=%h exp=%h", $time, 1'h0, 1'h1);
    summarize();
  end

  initial
  begin
    ddrb_burst_t b;
    ddrb_burst_t c;
    {rst, zq, prd, pwr, pidle} = 5'h11;
    repeat (6) @(posedge clk);
    #1 rst = 1'h0;
    idle(4);
    m_u.set_dll(1'h1);
    idle(1040);
    chk(36'(dll_locked), 36'h1);
    for (int i = 0; i < 64; i++)
    begin
      op(1'h0, 1'h1, rnd(1'h1, i));
      idle(1);
    end
    idle(6);
    for (int i = 0; i < 64; i++)
    begin
      op(1'h1, 1'h0, rnd(1'h0, i));
      idle(1);
    end
    idle(6);
    $display("test fill done");
    b = rnd(1'h0, 8);
    c = rnd(1'h0, 9);
    b.en[B1] = 4'hF;
    op(1'h0, 1'h1, b);
    idle(1);
    op(1'h0, 1'h1, c);
    idle(6);
    op(1'h1, 1'h0, b);
    idle(1);
    op(1'h1, 1'h0, c);
    idle(6);
    c = rnd(1'h1, 20);
    op(1'h1, 1'h1, c);
    op(1'h0, 1'h1, rnd(1'h1, 32));
    op(1'h0, 1'h1, rnd(1'h1, 40));
    op(1'h0, 1'h1, rnd(1'h1, 42));
    op(1'h1, 1'h0, rnd(1'h0, 48));
    op(1'h1, 1'h0, rnd(1'h0, 52));
    idle(6);
    foreach (c.data[k])
    begin
      op(1'h1, 1'h0, rnd(1'h0, 20 + k * 11));
      idle(1);
    end
    idle(6);
    $display("test corners done");
    for (int r = 0; r < 40; r++)
    begin
      op(1'h0, 1'h1, rnd(1'h0, ra()));
      op(1'h0, 1'($random(seed)), rnd(1'h0, ra()));
      op(1'h0, 1'h1, rnd(1'h0, ra()));
      idle(6);
      op(1'h1, 1'h0, rnd(1'h0, ra()));
      op(1'($random(seed)), 1'h0, rnd(1'h0, ra()));
      op(1'h1, 1'h0, rnd(1'h0, ra()));
      idle(5);
    end
    $display("test random done");
    m_u.set_dll(1'h0);
    idle(6);
    chk(36'(dll_locked), 36'h0);
    m_u.set_dll(1'h1);
    idle(1040);
    chk(36'(dll_locked), 36'h1);
    chk(36'(impedance_ready), 36'h1);
    $display("test dll done");
    summarize();
  end
endmodule // testbench
